// ==== design/chgopt_pkg.sv ====
/*
 * Constants shared by the charger option and voltage readback block:
 * command codes, field positions, reset values, limits and the
 * state encoding of the serial register port.
 * Assumes the block sits on the device's two-wire management bus.
 */
package chgopt_pkg;

   // ----------------------------------------------------------------
   // Command codes
   // ----------------------------------------------------------------
   localparam logic [7:0] CMD_VOLT_READBACK = 8'h26;
   localparam logic [7:0] CMD_OPTION_ONE = 8'h30;
   localparam logic [7:0] CMD_HOST_INPUT_LIMIT = 8'h3f;

   // ----------------------------------------------------------------
   // Option register layout and reset
   // ----------------------------------------------------------------
   localparam logic [15:0] OPT1_RESET = 16'h3300;
   localparam int BATMON_BIT = 15;
   localparam int HOTALERT_BIT = 14;
   localparam int PSCFG_HI = 13;
   localparam int PSCFG_LO = 12;
   localparam int INRES_BIT = 11;
   localparam int CHGRES_BIT = 10;
   localparam int GAIN_BIT = 9;
   localparam int FAST_BIT = 8;
   localparam logic [1:0] PSCFG_BUS_BAT = 2'h0;
   localparam logic [1:0] PSCFG_BUS = 2'h1;
   localparam logic [1:0] PSCFG_RSVD = 2'h2;
   localparam logic [1:0] PSCFG_OFF = 2'h3;

   // ----------------------------------------------------------------
   // Host input current limit: 7-bit code in bits 14:8
   // ----------------------------------------------------------------
   localparam logic [6:0] IIN_RESET = 7'h20;
   localparam logic [6:0] IIN_CAP_FAST = 7'h40; // 6.4 A at 100 mA per code
   localparam logic [6:0] IIN_CAP_WIDE = 7'h64; // 10 A at 100 mA per code
   localparam logic [6:0] IIN_CAP_NONE = 7'h7f;

   // ----------------------------------------------------------------
   // Voltage readback scale, in millivolts
   // ----------------------------------------------------------------
   localparam int VOLT_LSB_MV = 64;
   localparam int VOLT_OFFSET_MV = 2880;
   localparam int VOLT_FULL_MV = 19200;

   // ----------------------------------------------------------------
   // Serial port framing
   // ----------------------------------------------------------------
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   localparam logic [2:0] IDX_ADDR = 3'h0;
   localparam logic [2:0] IDX_CMD = 3'h1;
   localparam logic [2:0] IDX_LO = 3'h2;
   localparam logic [2:0] IDX_HI = 3'h3;
   localparam logic [2:0] IDX_DONE = 3'h4;
   localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h09;

   typedef enum logic [2:0] {S_IDLE, S_RECV, S_ACK, S_SEND, S_MACK, S_WAIT} chgopt_state_t;

endpackage

// ==== design/chgopt_regs.sv ====
/*
 * Charger option byte, host input current limit and system/battery
 * voltage readback, reached over a two-wire management bus slave
 * (write word and read word with repeated start).
 * Assumes the voltage codes and the low power mode level come from
 * logic on the same clock; the bus pins are asynchronous.
 */
// Functional notes
// - Readback word: system voltage code high byte, battery voltage code low byte.
// - Both readback codes scale 64 mV per code, 2.88 V to 19.2 V.
// - Option register resets to 3300h; config 11b, gain and fast set.
// - Bit 15 set turns battery current monitor buffer on; off by default.
// - Low power mode forces the battery current monitor buffer off.
// - Bit 14 enables low power hot alert; host avoids it with adapter.
// - Low power mode forces system power sensing and its buffer off.
// - Bit 11 picks input sense resistor: 0 is 10 mOhm, 1 is 5 mOhm.
// - Bit 10 picks charge sense resistor: 0 is 10 mOhm, 1 is 5 mOhm.
// - Bit 9 picks power output gain: 0 is 0.25, 1 is 1 uA/W.
// - Fast compensation with 5 mOhm input refuses host limit writes above 6.4 A.
// - Without fast compensation, 5 mOhm input accepts limits up to 10 A.
`timescale 1ns/1ps
module chgopt_regs
   import chgopt_pkg::*;
#(
   parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEFAULT
)
(
   input wire logic clock,                      // 25 MHz
   input wire logic resetn,                     // Async reset, active low
   input wire logic sclIn,                      // Bus clock pin level
   input wire logic sdaIn,                      // Bus data pin level
   output logic sdaOut,                         // Data pin drive value
   output logic sdaOe,                          // Data pin pulled low when high
   input wire logic lowPowerMode,               // Low power mode level
   input wire logic [7:0] sysVoltCode,          // System voltage code
   input wire logic [7:0] batVoltCode,          // Battery voltage code
   output logic batCurMonBufEn,                 // Battery current monitor buffer on
   output logic lowPowerHotAlertEn,             // Low power hot alert enable
   output logic powerSenseEn,                   // System power sensing on
   output logic [1:0] powerSenseConfig,         // Power sense selection field
   output logic inputSenseRes5m,                // Input sense resistor is 5 mOhm
   output logic chargeSenseRes5m,               // Charge sense resistor is 5 mOhm
   output logic powerSenseGainHigh,             // Gain 1 uA/W when high
   output logic fastCompEn,                     // Fast compensation enable
   output logic [6:0] hostInputCurrentLimit     // Host input current limit code
);

   // ----------------------------------------------------------------
   // Pin synchronisers and bus events
   // ----------------------------------------------------------------
   logic sclMeta, sclSync, sclPrev, sdaMeta, sdaSync, sdaPrev;
   logic next_sclMeta, next_sclSync, next_sclPrev;
   logic next_sdaMeta, next_sdaSync, next_sdaPrev;
   logic sclRise, sclFall, startEv, stopEv;

   always_comb
   begin
      next_sclMeta = sclIn;
      next_sclSync = sclMeta;
      next_sclPrev = sclSync;
      next_sdaMeta = sdaIn;
      next_sdaSync = sdaMeta;
      next_sdaPrev = sdaSync;
   end

   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         sclMeta <= 1'b1;
         sclSync <= 1'b1;
         sclPrev <= 1'b1;
         sdaMeta <= 1'b1;
         sdaSync <= 1'b1;
         sdaPrev <= 1'b1;
      end
      else
      begin
         sclMeta <= next_sclMeta;
         sclSync <= next_sclSync;
         sclPrev <= next_sclPrev;
         sdaMeta <= next_sdaMeta;
         sdaSync <= next_sdaSync;
         sdaPrev <= next_sdaPrev;
      end
   end

   // Only the second stage and its delayed copy feed event detection
   assign sclRise = sclSync & ~sclPrev;
   assign sclFall = ~sclSync & sclPrev;
   assign startEv = sclSync & sclPrev & sdaPrev & ~sdaSync;
   assign stopEv = sclSync & sclPrev & ~sdaPrev & sdaSync;

   // ----------------------------------------------------------------
   // Register state and read mux
   // ----------------------------------------------------------------
   logic [15:0] option1, next_option1;
   logic [6:0] hostLimit, next_hostLimit;
   logic written, next_written;
   logic commit;
   logic [7:0] cmd, shift, dataLo;
   logic [15:0] readWord;
   logic [6:0] limitCap;

   always_comb
   begin
      case (cmd)
         CMD_VOLT_READBACK: readWord = {sysVoltCode, batVoltCode};
         CMD_OPTION_ONE: readWord = option1;
         CMD_HOST_INPUT_LIMIT: readWord = {1'b0, hostLimit, 8'h00};
         default: readWord = 16'h0000;
      endcase
   end

   // Cap depends on the live resistor and compensation settings
   always_comb
   begin
      if (!option1[INRES_BIT])
         limitCap = IIN_CAP_NONE;
      else if (option1[FAST_BIT])
         limitCap = IIN_CAP_FAST;
      else
         limitCap = IIN_CAP_WIDE;
   end

   always_comb
   begin
      next_option1 = option1;
      next_hostLimit = hostLimit;
      next_written = written;
      if (commit)
      begin
         case (cmd)
            CMD_OPTION_ONE:
            begin
               next_option1 = {shift, dataLo};
               next_written = 1'b1;
            end
            CMD_HOST_INPUT_LIMIT:
            begin
               // Over-limit requests leave the old limit in place
               if (shift[6:0] <= limitCap)
                  next_hostLimit = shift[6:0];
            end
            default: ; // Readback and unmapped writes are dropped
         endcase
      end
   end

   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         option1 <= OPT1_RESET;
         hostLimit <= IIN_RESET;
         written <= 1'b0;
      end
      else
      begin
         option1 <= next_option1;
         hostLimit <= next_hostLimit;
         written <= next_written;
      end
   end

   // ----------------------------------------------------------------
   // Outputs to the analog side
   // ----------------------------------------------------------------
   assign batCurMonBufEn = option1[BATMON_BIT] & ~lowPowerMode;
   assign lowPowerHotAlertEn = option1[HOTALERT_BIT];
   assign powerSenseConfig = option1[PSCFG_HI:PSCFG_LO];
   // Reserved code 10b is treated like off so the circuit never runs undefined
   assign powerSenseEn = ~lowPowerMode & ((powerSenseConfig == PSCFG_BUS_BAT)
                         | (powerSenseConfig == PSCFG_BUS));
   assign inputSenseRes5m = option1[INRES_BIT];
   assign chargeSenseRes5m = option1[CHGRES_BIT];
   assign powerSenseGainHigh = option1[GAIN_BIT];
   assign fastCompEn = option1[FAST_BIT];
   assign hostInputCurrentLimit = hostLimit;

   // ----------------------------------------------------------------
   // Bus slave state machine
   // ----------------------------------------------------------------
   chgopt_state_t state, next_state;
   logic [3:0] bitCnt, next_bitCnt;
   logic [2:0] byteIdx, next_byteIdx;
   logic [7:0] next_cmd, next_shift, next_dataLo, hiByte, next_hiByte;
   logic isRead, next_isRead, masterAck, next_masterAck, sentHi, next_sentHi;
   logic next_commit, next_sdaOe;

   always_comb
   begin
      next_state = state;
      next_bitCnt = bitCnt;
      next_byteIdx = byteIdx;
      next_cmd = cmd;
      next_shift = shift;
      next_dataLo = dataLo;
      next_hiByte = hiByte;
      next_isRead = isRead;
      next_masterAck = masterAck;
      next_sentHi = sentHi;
      next_commit = 1'b0;
      if (startEv)
      begin
         next_state = S_RECV;
         next_bitCnt = 4'h0;
         next_byteIdx = IDX_ADDR;
      end
      else if (stopEv)
         next_state = S_IDLE;
      else
      begin
         case (state)
            S_RECV:
            begin
               if (sclRise)
               begin
                  next_shift = {shift[6:0], sdaSync};
                  next_bitCnt = bitCnt + 4'h1;
               end
               else if (sclFall && bitCnt == BITS_PER_BYTE)
               begin
                  next_bitCnt = 4'h0;
                  next_state = S_ACK;
                  next_byteIdx = byteIdx + 3'h1;
                  case (byteIdx)
                     IDX_ADDR:
                     begin
                        if (shift[7:1] != DEV_ADDR)
                           next_state = S_WAIT;
                        next_isRead = shift[0];
                        // Whole word captured at once so the two bytes match
                        next_shift = readWord[7:0];
                        next_hiByte = readWord[15:8];
                        next_sentHi = 1'b0;
                     end
                     IDX_CMD: next_cmd = shift;
                     IDX_LO: next_dataLo = shift;
                     default: next_commit = 1'b1;
                  endcase
               end
            end
            S_ACK:
            begin
               if (sclFall)
               begin
                  if (isRead)
                     next_state = S_SEND;
                  else if (byteIdx == IDX_DONE)
                     next_state = S_WAIT;
                  else
                     next_state = S_RECV;
               end
            end
            S_SEND:
            begin
               if (sclFall)
               begin
                  next_shift = {shift[6:0], 1'b0};
                  next_bitCnt = bitCnt + 4'h1;
                  if (bitCnt == BITS_PER_BYTE - 4'h1)
                     next_state = S_MACK;
               end
            end
            S_MACK:
            begin
               if (sclRise)
                  next_masterAck = ~sdaSync;
               else if (sclFall)
               begin
                  next_bitCnt = 4'h0;
                  if (masterAck && !sentHi)
                  begin
                     next_shift = hiByte;
                     next_sentHi = 1'b1;
                     next_state = S_SEND;
                  end
                  else
                     next_state = S_WAIT;
               end
            end
            S_IDLE, S_WAIT: ;
            default: next_state = S_IDLE;
         endcase
      end
      next_sdaOe = (next_state == S_ACK) | ((next_state == S_SEND) & ~next_shift[7]);
   end

   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         state <= S_IDLE;
         bitCnt <= 4'h0;
         byteIdx <= IDX_ADDR;
         cmd <= 8'h00;
         shift <= 8'h00;
         dataLo <= 8'h00;
         hiByte <= 8'h00;
         isRead <= 1'b0;
         masterAck <= 1'b0;
         sentHi <= 1'b0;
         commit <= 1'b0;
         sdaOe <= 1'b0;
      end
      else
      begin
         state <= next_state;
         bitCnt <= next_bitCnt;
         byteIdx <= next_byteIdx;
         cmd <= next_cmd;
         shift <= next_shift;
         dataLo <= next_dataLo;
         hiByte <= next_hiByte;
         isRead <= next_isRead;
         masterAck <= next_masterAck;
         sentHi <= next_sentHi;
         commit <= next_commit;
         sdaOe <= next_sdaOe;
      end
   end

   // Open drain: the pin is only ever pulled low
   assign sdaOut = 1'b0;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (!resetn);

   sequence optWrite;
      commit && cmd == CMD_OPTION_ONE;
   endsequence

   sequence iinWrite;
      commit && cmd == CMD_HOST_INPUT_LIMIT;
   endsequence

   reset_value_a: assert property (!written |-> option1 == OPT1_RESET)
      else $error("option register left its reset value without a write");
   monitor_enable_a: assert property (optWrite ##1 !lowPowerMode
      |-> batCurMonBufEn == $past(shift[7]))
      else $error("battery monitor buffer does not follow bit 15");
   monitor_mask_a: assert property (lowPowerMode |-> !batCurMonBufEn)
      else $error("battery monitor buffer on in low power mode");
   sense_mask_a: assert property (lowPowerMode |-> !powerSenseEn)
      else $error("power sensing on in low power mode");
   sense_off_a: assert property (optWrite ##1 (option1[PSCFG_HI:PSCFG_LO] == PSCFG_OFF)
      |-> !powerSenseEn)
      else $error("power sensing on with config off");
   fast_clamp_a: assert property (iinWrite ##0 (inputSenseRes5m && fastCompEn
      && shift[6:0] > IIN_CAP_FAST) |=> $stable(hostLimit))
      else $error("limit above 6.4 A accepted with fast compensation");
   wide_clamp_a: assert property (iinWrite ##0 (inputSenseRes5m && !fastCompEn
      && shift[6:0] <= IIN_CAP_WIDE) |=> hostLimit == $past(shift[6:0]))
      else $error("limit up to 10 A refused without fast compensation");
   readback_write_a: assert property (commit && cmd == CMD_VOLT_READBACK
      |=> $stable(option1) && $stable(hostLimit))
      else $error("write to readback register changed state");
   readback_load_a: assert property (state == S_RECV && byteIdx == IDX_ADDR && sclFall
      && bitCnt == BITS_PER_BYTE && cmd == CMD_VOLT_READBACK && !startEv && !stopEv
      |=> hiByte == $past(sysVoltCode) && shift == $past(batVoltCode))
      else $error("readback bytes swapped or stale");

endmodule

// ==== test/chgopt_host_model.sv ====
/*
 * Bus master model: bit-level write word and read word towards the
 * charger option block, open-drain data on a pulled-up wire.
 * Assumes the bench clock; every bus phase lasts 8 clock cycles.
 */
`timescale 1ns/1ps
module chgopt_host_model
   import chgopt_pkg::*;
(
   input wire logic clock, // Bench clock
   input wire logic sdaOe, // Device pulls data low
   output logic sclLine, // Bus clock wire
   output logic sdaLine // Resolved data wire
);
   logic hostLow;
   logic bitIn;
   // Pull-up: the wire reads high unless some party pulls it low
   assign sdaLine = ~(hostLow | sdaOe);
   initial
   begin
      sclLine = 1'b1;
      hostLow = 1'b0;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clock);
   endtask
   // Data only moves while the clock is low, so no false start or stop
   task automatic clockBit(input logic b, output logic s);
      tick(4);
      hostLow <= ~b;
      tick(4);
      sclLine <= 1'b1;
      tick(8);
      s = sdaLine;
      sclLine <= 1'b0;
   endtask
   // Serves both the first start and the repeated start
   task automatic startCond();
      tick(4);
      hostLow <= 1'b0;
      tick(4);
      sclLine <= 1'b1;
      tick(8);
      hostLow <= 1'b1;
      tick(8);
      sclLine <= 1'b0;
   endtask
   task automatic stopCond();
      tick(4);
      hostLow <= 1'b1;
      tick(4);
      sclLine <= 1'b1;
      tick(8);
      hostLow <= 1'b0;
      tick(8);
   endtask
   task automatic sendByte(input logic [7:0] d, inout logic ok);
      for (int i = 7; i >= 0; i--)
         clockBit(d[i], bitIn);
      clockBit(1'b1, bitIn);
      ok = ok & ~bitIn;
   endtask
   task automatic recvByte(input logic last, output logic [7:0] d);
      for (int i = 7; i >= 0; i--)
      begin
         clockBit(1'b1, bitIn);
         d[i] = bitIn;
      end
      clockBit(last, bitIn);
   endtask
   task automatic writeWord(input logic [6:0] a, input logic [7:0] cmd,
                            input logic [15:0] w, output logic ok);
      ok = 1'b1;
      startCond();
      sendByte({a, 1'b0}, ok);
      sendByte(cmd, ok);
      sendByte(w[7:0], ok);
      sendByte(w[15:8], ok);
      stopCond();
   endtask
   // Low byte first; acknowledge it, refuse the high byte to end
   task automatic readWord(input logic [6:0] a, input logic [7:0] cmd,
                           output logic [15:0] w, output logic ok);
      ok = 1'b1;
      startCond();
      sendByte({a, 1'b0}, ok);
      sendByte(cmd, ok);
      startCond();
      sendByte({a, 1'b1}, ok);
      recvByte(1'b0, w[7:0]);
      recvByte(1'b1, w[15:8]);
      stopCond();
   endtask
endmodule

// ==== test/charger_option_and_voltage_readback_bench.sv ====
/*
 * Self-checking bench for the charger option and voltage readback
 * block, with a reference model of the registers and outputs.
 * Assumes the bus master model in chgopt_host_model.
 */
`timescale 1ns/1ps
module charger_option_and_voltage_readback_bench;
   import chgopt_pkg::*;
   localparam logic [6:0] ADDR = 7'h0b;
   logic clock = 1'b0;
   logic resetn = 1'b0;
   logic lowPowerMode = 1'b0;
   logic [7:0] sysVoltCode = 8'h00;
   logic [7:0] batVoltCode = 8'h00;
   logic sclLine;
   logic sdaLine;
   logic sdaOe;
   wire logic [15:0] outs;
   wire logic sdaDrive;
   logic [15:0] opt = 16'h3300;
   logic [6:0] lim = 7'h20;
   logic [7:0] rnd = 8'h5b;
   logic [15:0] word;
   logic ok;
   logic [6:0] vals [6] = '{7'h41, 7'h40, 7'h65, 7'h64, 7'h7f, 7'h10};
   int badCount = 0;
   int nTests = 0;
   always #20 clock = ~clock;
   chgopt_host_model u_host (.clock(clock), .sdaOe(sdaOe), .sclLine(sclLine),
                             .sdaLine(sdaLine));
   chgopt_regs #(.DEV_ADDR(ADDR)) u_dut (
      .clock(clock), .resetn(resetn), .sclIn(sclLine), .sdaIn(sdaLine),
      .sdaOut(sdaDrive), .sdaOe(sdaOe), .lowPowerMode(lowPowerMode),
      .sysVoltCode(sysVoltCode), .batVoltCode(batVoltCode),
      .batCurMonBufEn(outs[15]), .lowPowerHotAlertEn(outs[14]),
      .powerSenseEn(outs[13]), .powerSenseConfig(outs[12:11]),
      .inputSenseRes5m(outs[10]), .chargeSenseRes5m(outs[9]),
      .powerSenseGainHigh(outs[8]), .fastCompEn(outs[7]),
      .hostInputCurrentLimit(outs[6:0]));
   // ----------------------------------------------------------------
   // Reference model and checks
   // ----------------------------------------------------------------
   function automatic logic [7:0] lfsrNext(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   task automatic completeRun();
      if (badCount == 0 && nTests > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      nTests++;
      if (got !== exp)
      begin
         badCount++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // Sensing is on only for configs 00 and 01, and never in low power
   task automatic checkOuts();
      check(outs, {opt[15] & ~lowPowerMode, opt[14], ~lowPowerMode & ~opt[13],
                   opt[13:8], lim});
      // Open drain: the data pin may only ever be pulled low
      check({15'h0, sdaDrive}, 16'h0000);
   endtask
   task automatic wr(input logic [7:0] cmd, input logic [15:0] w);
      logic [6:0] cap;
      cap = !opt[11] ? 7'd127 : (opt[8] ? 7'd64 : 7'd100);
      u_host.writeWord(ADDR, cmd, w, ok);
      if (cmd == CMD_OPTION_ONE)
         opt = w;
      if (cmd == CMD_HOST_INPUT_LIMIT && w[14:8] <= cap)
         lim = w[14:8];
      check({15'h0, ok}, 16'h0001);
   endtask
   task automatic rd(input logic [7:0] cmd, input logic [15:0] exp);
      u_host.readWord(ADDR, cmd, word, ok);
      check({ok, word}, {1'b1, exp});
   endtask
   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial
   begin
      repeat (4) @(posedge clock);
      resetn <= 1'b1;
      repeat (4) @(posedge clock);
      checkOuts();
      rd(CMD_OPTION_ONE, 16'h3300);
      rd(CMD_HOST_INPUT_LIMIT, {1'b0, lim, 8'h00});
      rd(8'h55, 16'h0000);
      for (int i = 0; i < 3; i++)
      begin
         rnd = lfsrNext(rnd);
         sysVoltCode <= rnd;
         batVoltCode <= ~rnd ^ 8'h3c;
         @(posedge clock);
         rd(CMD_VOLT_READBACK, {sysVoltCode, batVoltCode});
      end
      wr(CMD_VOLT_READBACK, 16'ha5a5);
      rd(CMD_VOLT_READBACK, {sysVoltCode, batVoltCode});
      rd(CMD_OPTION_ONE, opt);
      // Every config code, with and without low power mode
      for (int i = 0; i < 8; i++)
      begin
         rnd = lfsrNext(rnd);
         lowPowerMode <= i[2];
         wr(CMD_OPTION_ONE, {i[0], rnd[6], i[1:0], rnd[3:0], ~rnd});
         @(posedge clock);
         checkOuts();
         rd(CMD_OPTION_ONE, opt);
      end
      lowPowerMode <= 1'b0;
      // Each resistor and compensation pair, limits either side of cap
      for (int c = 0; c < 4; c++)
      begin
         wr(CMD_OPTION_ONE, {4'h3, c[1], 2'b01, c[0], 8'h00});
         foreach (vals[k])
         begin
            wr(CMD_HOST_INPUT_LIMIT, {1'b0, vals[k], 8'h00});
            checkOuts();
         end
      end
      rd(CMD_HOST_INPUT_LIMIT, {1'b0, lim, 8'h00});
      u_host.writeWord(ADDR ^ 7'h01, CMD_OPTION_ONE, 16'h0000, ok);
      check({15'h0, ok}, 16'h0000);
      checkOuts();
      wr(CMD_OPTION_ONE, 16'hcc00);
      resetn <= 1'b0;
      repeat (2) @(posedge clock);
      resetn <= 1'b1;
      opt = 16'h3300;
      lim = 7'h20;
      repeat (4) @(posedge clock);
      checkOuts();
      completeRun();
   end
   // Full run is about 40000 cycles; twice that means a hang
   initial
   begin
      repeat (80000) @(posedge clock);
      badCount++;
      completeRun();
   end
endmodule
